/* rtl/mvo_consts.vh */
// Constants of the output-adjustment stage: values, limits, codes, offsets.
// Assumes values are signed tenths of a percent (1000 means 100.0 %).
`ifndef MVO_CONSTS_VH
`define MVO_CONSTS_VH

`define MVO_W            12
`define MVO_PCT_0        12'sd0
`define MVO_PCT_100      12'sd1000
`define MVO_STD_MIN      -12'sd50
`define MVO_STD_MAX      12'sd1050
`define MVO_HC_MIN       -12'sd1050
`define MVO_HC_MAX       12'sd1050
`define MVO_STOP_RST     12'sd0
`define MVO_ERR_RST      12'sd0
`define MVO_LIM_HI_RST   12'sd1000
`define MVO_LIM_LO_RST   12'sd0
`define MVO_MODE_STD     2'h0
`define MVO_MODE_HC      2'h1
`define MVO_MODE_VALVE   2'h2
`define MVO_VS_HOLD      2'h0
`define MVO_VS_OPEN      2'h1
`define MVO_VS_CLOSE     2'h2
`define MVO_REG_CTRL     4'h0
`define MVO_REG_LIM_HI   4'h1
`define MVO_REG_LIM_LO   4'h2
`define MVO_REG_MANUAL   4'h3
`define MVO_REG_STOP     4'h4
`define MVO_REG_ERR      4'h5
`define MVO_REG_STATUS   4'h6
`define MVO_REG_OUT      4'h7
`define MVO_CTRL_MODE_LO 0
`define MVO_CTRL_MODE_HI 1
`define MVO_CTRL_STERR   2
`define MVO_CTRL_MLIM    3
`define MVO_CTRL_DIRECT  4
`define MVO_CTRL_FLOAT   5
`define MVO_CTRL_STOPVS  7
`define MVO_CTRL_ERRVS   9
`define MVO_CTRL_RST     16'h0000
`define MVO_POS_DB       12'sd5

`endif

/* rtl/mvo_clamp.v */
// Clamps a signed value into a lower and upper bound.
// Assumes lower is not above upper; otherwise values below lower give lower, all others give upper.
`timescale 1ns/100ps
`default_nettype none

module mvo_clamp #(
    parameter W = 12
) (
    // Value and bounds.
    input  wire signed [W-1:0] value,
    input  wire signed [W-1:0] lower,
    input  wire signed [W-1:0] upper,
    // Result.
    output wire signed [W-1:0] result
);

    assign result = (value < lower) ? lower :
                    (value > upper) ? upper : value;

endmodule

`default_nettype wire

/* rtl/mvo_output_select.v */
// Output-adjustment stage: limits the manipulated value, picks substitutes.
// Assumes all inputs except the three error pins are on clk_sys; event levels arrive from pins.
// Operation
// - Clamp computed value between output limits.
// - Priority manual, then stop, then error.
// - Manual value limited when limit enable on.
// - Heating/cooling shares one limit pair.
// - Stop/error values used only when enabled.
// - Negative substitute cools in heating/cooling mode only, positive heats.
// - Stop and error values reset to zero.
// - Valve state open, close or hold.
// - Valve state defaults to hold.
// - Direct setting: stop value is target opening.
// - Accept substitutes only in mode range.
// - Potentiometer error: open at 100, close at 0.
// - Error value on sensor or remote error; pot error only with direct, non-floating valve setting.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mvo_consts.vh"

module mvo_output_select #(
    parameter W = `MVO_W
) (
    // Clock and reset.
    input  wire                clk_sys,
    input  wire                reset_n,
    // Register port.
    input  wire [3:0]          reg_addr,
    input  wire [15:0]         reg_wdata,
    input  wire                reg_wr,
    input  wire                reg_rd,
    output reg  [15:0]         reg_rdata,
    // Control algorithm side.
    input  wire signed [W-1:0] manipulated_value,
    input  wire                control_period,
    input  wire                manual_mode,
    input  wire                stop_mode,
    input  wire signed [W-1:0] valve_position,
    // Error pins.
    input  wire                sensor_err_pin,
    input  wire                remote_setpoint_err_pin,
    input  wire                pot_err_pin,
    // Outputs.
    output reg  [W-1:0]        heat_out,
    output reg  [W-1:0]        cool_out,
    output reg                 valve_open,
    output reg                 close_valve_state
);

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    reg [2:0] sync_a;
    reg [2:0] sync_b;
    wire      sensor_err = sync_b[0];
    wire      rsp_err    = sync_b[1];
    wire      pot_err    = sync_b[2];

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {pot_err_pin, remote_setpoint_err_pin, sensor_err_pin};
            sync_b <= sync_a;
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    reg        [15:0]  ctrl;
    reg signed [W-1:0] lim_hi;
    reg signed [W-1:0] lim_lo;
    reg signed [W-1:0] manual_val;
    reg signed [W-1:0] stop_val;
    reg signed [W-1:0] err_val;
    reg        [3:0]   status;

    wire [1:0] mode     = ctrl[`MVO_CTRL_MODE_HI:`MVO_CTRL_MODE_LO];
    wire       sterr_en = ctrl[`MVO_CTRL_STERR];
    wire       mlim_en  = ctrl[`MVO_CTRL_MLIM];
    wire       direct   = ctrl[`MVO_CTRL_DIRECT];
    wire       floating = ctrl[`MVO_CTRL_FLOAT];
    wire [1:0] stop_vs  = ctrl[`MVO_CTRL_STOPVS+1:`MVO_CTRL_STOPVS];
    wire [1:0] err_vs   = ctrl[`MVO_CTRL_ERRVS+1:`MVO_CTRL_ERRVS];
    wire       use_pos  = (mode == `MVO_MODE_VALVE) && direct && !floating;

    // A substitute outside the range of the present mode is refused and the
    // register keeps its old value, so software can read back what stuck.
    function in_range;
        input signed [W-1:0] v;
        input        [1:0]   m;
        begin
            if (m == `MVO_MODE_HC)
                in_range = (v >= `MVO_HC_MIN) && (v <= `MVO_HC_MAX);
            else
                in_range = (v >= `MVO_STD_MIN) && (v <= `MVO_STD_MAX);
        end
    endfunction

    wire signed [W-1:0] wval = reg_wdata[W-1:0];

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl       <= `MVO_CTRL_RST;
            lim_hi     <= `MVO_LIM_HI_RST;
            lim_lo     <= `MVO_LIM_LO_RST;
            manual_val <= `MVO_PCT_0;
            stop_val   <= `MVO_STOP_RST;
            err_val    <= `MVO_ERR_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `MVO_REG_CTRL: begin
                    ctrl <= reg_wdata;
                end
                `MVO_REG_LIM_HI: begin
                    lim_hi <= wval;
                end
                `MVO_REG_LIM_LO: begin
                    lim_lo <= wval;
                end
                `MVO_REG_MANUAL: begin
                    manual_val <= wval;
                end
                `MVO_REG_STOP: begin
                    if (sterr_en && in_range(wval, mode))
                        stop_val <= wval;
                end
                `MVO_REG_ERR: begin
                    if (sterr_en && in_range(wval, mode))
                        err_val <= wval;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************
    // Selection
    // ****************************************************
    wire signed [W-1:0] mv_clamped;
    wire signed [W-1:0] man_clamped;

    // One limit pair serves heating and cooling alike.
    mvo_clamp #(.W(W)) u_clamp_mv (
        .value  (manipulated_value),
        .lower  (lim_lo),
        .upper  (lim_hi),
        .result (mv_clamped)
    );

    mvo_clamp #(.W(W)) u_clamp_man (
        .value  (manual_val),
        .lower  (lim_lo),
        .upper  (lim_hi),
        .result (man_clamped)
    );

    wire any_err = sensor_err || rsp_err ||
                   (pot_err && use_pos);
    wire sel_stop = sterr_en && stop_mode;
    wire sel_err  = sterr_en && any_err;

    reg signed [W-1:0] next_value;
    reg        [1:0]   next_vs;
    reg                next_use_vs;
    reg                next_pot_rule;

    always @* begin
        next_vs       = `MVO_VS_HOLD;
        next_use_vs   = 1'b0;
        next_pot_rule = 1'b0;
        if (manual_mode) begin
            next_value = mlim_en ? man_clamped : manual_val;
        end else if (sel_stop) begin
            next_value  = stop_val;
            next_vs     = stop_vs;
            next_use_vs = (mode == `MVO_MODE_VALVE) && !use_pos;
        end else if (sel_err) begin
            next_value  = err_val;
            next_vs     = err_vs;
            next_use_vs = (mode == `MVO_MODE_VALVE) && !use_pos;
            next_pot_rule = pot_err && use_pos;
        end else begin
            next_value = mv_clamped;
        end
    end

    // ****************************************************
    // Output stage
    // ****************************************************
    // Outputs only move on control_period so downstream sees one value
    // per period; a change of condition lands on the following period.
    wire signed [W-1:0] neg_value = -next_value;
    wire signed [W-1:0] pos_err   = next_value - valve_position;

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            heat_out          <= {W{1'b0}};
            cool_out          <= {W{1'b0}};
            valve_open        <= 1'b0;
            close_valve_state <= 1'b0;
            status            <= 4'h0;
        end else if (control_period) begin
            status <= {next_use_vs, sel_err, sel_stop, manual_mode};
            heat_out          <= {W{1'b0}};
            cool_out          <= {W{1'b0}};
            valve_open        <= 1'b0;
            close_valve_state <= 1'b0;
            if (mode == `MVO_MODE_VALVE) begin
                if (next_pot_rule) begin
                    valve_open        <= (next_value >= `MVO_PCT_100);
                    close_valve_state <= (next_value <= `MVO_PCT_0);
                end else if (next_use_vs) begin
                    valve_open        <= (next_vs == `MVO_VS_OPEN);
                    close_valve_state <= (next_vs == `MVO_VS_CLOSE);
                end else if (use_pos) begin
                    valve_open        <= (pos_err > `MVO_POS_DB);
                    close_valve_state <= (pos_err < -`MVO_POS_DB);
                end
            end else if (next_value < `MVO_PCT_0) begin
                if (mode == `MVO_MODE_HC)
                    cool_out <= neg_value;
            end else begin
                heat_out <= next_value;
            end
        end
    end

    // ****************************************************
    // Read port
    // ****************************************************
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `MVO_REG_CTRL:   reg_rdata <= ctrl;
                `MVO_REG_LIM_HI: reg_rdata <= {{(16-W){lim_hi[W-1]}}, lim_hi};
                `MVO_REG_LIM_LO: reg_rdata <= {{(16-W){lim_lo[W-1]}}, lim_lo};
                `MVO_REG_MANUAL: reg_rdata <=
                                     {{(16-W){manual_val[W-1]}}, manual_val};
                `MVO_REG_STOP:   reg_rdata <=
                                     {{(16-W){stop_val[W-1]}}, stop_val};
                `MVO_REG_ERR:    reg_rdata <=
                                     {{(16-W){err_val[W-1]}}, err_val};
                `MVO_REG_STATUS: reg_rdata <= {12'h000, status};
                `MVO_REG_OUT:    reg_rdata <= {14'h0000,
                                     close_valve_state, valve_open};
                default:         reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

/* testbench/mvo_monitor.sv */
// Checker of the output stage; it watches the top module's ports only.
// Assumes the register map and control layout of the shared constants.
`timescale 1ns/100ps
`default_nettype none
`include "mvo_consts.vh"
module mvo_monitor #(
    parameter W = 12
) (
    input wire logic                clk_sys, reset_n, reg_wr, reg_rd,
    input wire logic [3:0]          reg_addr,
    input wire logic [15:0]         reg_wdata, reg_rdata,
    input wire logic signed [W-1:0] manipulated_value, valve_position,
    input wire logic                control_period, manual_mode, stop_mode,
    input wire logic                sensor_err_pin, remote_setpoint_err_pin,
    input wire logic                pot_err_pin, valve_open, close_valve_state,
    input wire logic [W-1:0]        heat_out, cool_out
);
    // Shadow copies follow the writes, refusing substitutes as the stage does.
    reg        [15:0]  ctl;
    reg signed [W-1:0] hi, lo, man, stp, err;
    wire signed [W-1:0] v = reg_wdata[W-1:0];
    wire hc = ctl[1:0] == `MVO_MODE_HC;
    wire ok = ctl[2] && v <= `MVO_HC_MAX
              && v >= (hc ? `MVO_HC_MIN : `MVO_STD_MIN);
    wire signed [W-1:0] cm  = manipulated_value < lo ? lo :
                              manipulated_value > hi ? hi : manipulated_value;
    wire signed [W-1:0] cmn = man < lo ? lo : man > hi ? hi : man;
    wire signed [W-1:0] sel = manual_mode ? (ctl[3] ? cmn : man) :
                              (ctl[2] && stop_mode) ? stp : cm;
    wire [W-1:0] eh = sel > 0 ? sel : '0;
    wire [W-1:0] ec = (hc && sel < 0) ? -sel : '0;
    wire [W-1:0] ee = err > 0 ? err : '0;
    wire po = err >= `MVO_PCT_100;
    wire pc = err <= `MVO_PCT_0;
    wire [1:0] sst = ctl[8:7];
    wire signed [W-1:0] shv = reg_addr == 4'h1 ? hi : reg_addr == 4'h2 ? lo :
                              reg_addr == 4'h3 ? man : reg_addr == 4'h4 ? stp : err;
    wire [15:0] shx = {{(16-W){shv[W-1]}}, shv};
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ctl <= `MVO_CTRL_RST;
            hi  <= `MVO_LIM_HI_RST;
            lo  <= `MVO_LIM_LO_RST;
            man <= '0;
            stp <= `MVO_STOP_RST;
            err <= `MVO_ERR_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `MVO_REG_CTRL:   ctl <= reg_wdata;
                `MVO_REG_LIM_HI: hi <= v;
                `MVO_REG_LIM_LO: lo <= v;
                `MVO_REG_MANUAL: man <= v;
                `MVO_REG_STOP:   stp <= ok ? v : stp;
                `MVO_REG_ERR:    err <= ok ? v : err;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_heat;
        control_period && !ctl[1] && (manual_mode || !ctl[2] || stop_mode)
            |=> heat_out == $past(eh);
    endproperty
    a_heat: assert property (p_heat) else $error("heat wrong");
    property p_cool;
        control_period && !ctl[1] && (manual_mode || !ctl[2] || stop_mode)
            |=> cool_out == $past(ec);
    endproperty
    a_cool: assert property (p_cool) else $error("cool wrong");
    property p_err;
        sensor_err_pin [*4] ##0 (control_period && ctl[1:0] == 2'h0
            && ctl[2] && !manual_mode && !stop_mode) |=> heat_out == $past(ee);
    endproperty
    a_err: assert property (p_err) else $error("error value unused");
    property p_pot;
        pot_err_pin [*4] ##0 (control_period && ctl[1:0] == 2'h2 && ctl[4]
            && !ctl[5] && ctl[2] && !manual_mode && !stop_mode)
            |=> valve_open == $past(po) && close_valve_state == $past(pc);
    endproperty
    a_pot: assert property (p_pot) else $error("pot error drive");
    property p_state;
        control_period && ctl[1:0] == 2'h2 && !ctl[4] && ctl[2] && stop_mode
            && !manual_mode |=> {close_valve_state, valve_open} == $past(sst);
    endproperty
    a_state: assert property (p_state) else $error("valve state");
    property p_hold;
        !control_period
            |=> $stable({heat_out, cool_out, valve_open, close_valve_state});
    endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_rd;
        reg_rd && reg_addr >= 4'h1 && reg_addr <= 4'h5 |=> reg_rdata == $past(shx);
    endproperty
    a_rd: assert property (p_rd) else $error("read data");
    property p_zero;
        !reg_rd || reg_addr > 4'h7 |=> reg_rdata == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("idle read data");
endmodule
bind mvo_output_select mvo_monitor #(.W(W)) mvo_monitor_inst (
    .clk_sys, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .manipulated_value, .valve_position, .control_period, .manual_mode,
    .stop_mode, .sensor_err_pin, .remote_setpoint_err_pin, .pot_err_pin,
    .valve_open, .close_valve_state, .heat_out, .cool_out
);
`default_nettype wire

/* testbench/mvo_plant.sv */
// Upstream algorithm and valve model: period pulses, value, valve travel.
// Assumes the stage loads its outputs on each period pulse.
`timescale 1ns/100ps
`default_nettype none
module mvo_plant (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic signed [11:0] mv_req,
    input  wire logic               valve_open,
    input  wire logic               close_valve_state,
    output logic signed [11:0]      manipulated_value,
    output logic signed [11:0]      valve_position,
    output logic                    control_period
);
    logic [2:0] tick;
    // One step per period, so the dead band can never be jumped over.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            tick <= 3'h0;
            control_period <= 1'b0;
            manipulated_value <= 12'sh000;
            valve_position <= 12'sh028;
        end else begin
            tick <= tick + 3'h1;
            control_period <= (tick == 3'h7);
            manipulated_value <= mv_req;
            if (control_period)
                valve_position <= valve_position + {11'h0, valve_open}
                                  - {11'h0, close_valve_state};
        end
    end
endmodule
`default_nettype wire

/* testbench/mvo_output_select_tb.sv */
// Self-checking bench of the output stage through its register port.
// Assumes outputs load on the period pulse made by the plant model.
`timescale 1ns/100ps
`default_nettype none
module mvo_output_select_tb;
    logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic manual_mode = 0, stop_mode = 0;
    logic sensor_err = 0, remote_err = 0, pot_err = 0;
    logic signed [11:0] mv_req = 12'sh000;
    wire signed [11:0] mv, vpos;
    wire period, valve_open, close_valve_state;
    wire [15:0] reg_rdata;
    wire [11:0] heat_out, cool_out;
    int failures = 0, compares = 0, cycles = 0;
    logic [15:0] pv[3] = '{16'h03e8, 16'h0000, 16'h01f4};
    logic [1:0] pe[3] = '{2'h1, 2'h2, 2'h0};
    mvo_output_select mvo_output_select_inst (.clk_sys, .reset_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .manipulated_value(mv),
        .control_period(period), .manual_mode, .stop_mode,
        .valve_position(vpos), .sensor_err_pin(sensor_err),
        .remote_setpoint_err_pin(remote_err), .pot_err_pin(pot_err),
        .heat_out, .cool_out, .valve_open, .close_valve_state);
    mvo_plant mvo_plant_inst (.clk_sys, .reset_n, .mv_req, .valve_open,
        .close_valve_state, .manipulated_value(mv), .valve_position(vpos),
        .control_period(period));
    initial forever #5 clk_sys = ~clk_sys;
    task chk(input [15:0] seen, input [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task rd(input [3:0] a, input [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 chk(reg_rdata, exp);
    endtask
    // Two periods, so the pin synchronisers have caught up before a check.
    task upd;
        repeat (2) @(posedge clk_sys iff period);
        #1;
    endtask
    task outs(input [11:0] h, input [11:0] c);
        chk({4'h0, heat_out}, {4'h0, h});
        chk({4'h0, cool_out}, {4'h0, c});
    endtask
    task wrap_up;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up;
        end
    end
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1;
        for (int a = 0; a < 9; a++)
            rd(4'(a), a == 1 ? 16'h03e8 : 16'h0000);
        wr(4, 16'h012c);
        rd(4, 16'h0000);
        wr(1, 16'h0320);
        wr(2, 16'h0064);
        mv_req <= 12'sd1200;
        upd;
        outs(800, 0);
        mv_req <= -12'sd300;
        upd;
        outs(100, 0);
        wr(0, 16'h0005);
        wr(2, 16'hfda8);
        mv_req <= -12'sd900;
        upd;
        outs(0, 600);
        wr(4, 16'hfbdc);
        rd(4, 16'h0000);
        wr(4, 16'hfbe6);
        rd(4, 16'hfbe6);
        stop_mode <= 1;
        upd;
        outs(0, 1050);
        wr(3, 16'h0384);
        manual_mode <= 1;
        upd;
        outs(900, 0);
        wr(0, 16'h000d);
        upd;
        outs(800, 0);
        rd(6, 16'h0003);
        manual_mode <= 0;
        stop_mode <= 0;
        wr(0, 16'h0004);
        wr(5, 16'h041b);
        rd(5, 16'h0000);
        wr(5, 16'h041a);
        for (int k = 0; k < 2; k++) begin
            {remote_err, sensor_err} <= 2'(k + 1);
            upd;
            outs(1050, 0);
        end
        {remote_err, sensor_err} <= 2'h0;
        stop_mode <= 1;
        for (int s = 0; s < 3; s++) begin
            wr(0, 16'(16'h0006 | (s << 7)));
            upd;
            chk({close_valve_state, valve_open}, 16'(s));
        end
        rd(7, 16'h0002);
        stop_mode <= 0;
        wr(0, 16'h0426);
        sensor_err <= 1;
        upd;
        chk({close_valve_state, valve_open}, 16'h0002);
        sensor_err <= 0;
        wr(0, 16'h0016);
        pot_err <= 1;
        for (int k = 0; k < 3; k++) begin
            wr(4, pv[k]);
            wr(5, pv[k]);
            upd;
            chk({close_valve_state, valve_open}, pe[k]);
        end
        pot_err <= 0;
        stop_mode <= 1;
        wr(4, 16'h0000);
        repeat (40) upd;
        chk({close_valve_state, valve_open}, 16'h0000);
        chk(16'(vpos >= -12'sd5 && vpos <= 12'sd5), 16'h0001);
        wrap_up;
    end
endmodule
`default_nettype wire
